/* verilog/fsd_top.sv */
// Summary of operation
// - fast mode averages 2, 8 or 16 sinc outputs
// - both averaging bits zero disables fast mode
// - in fast mode, sinc3 rate is clock over (2+avg)*1024*word
// - rate word is unsigned ten bits
// - all rates derive from master clock
// - fast mode settles within one output period
// - in fast mode, channel change gives valid first conversion immediately
// - single channel keeps converting through input steps
// - sinc notch at clock over 1024*word
// - in fast mode, chop swaps polarity and averages conversion pairs
// - chop keeps rate, settling becomes two periods
// - sixty hertz notch at word 96, average 16
// - in fast mode without chop, multichannel throughput equals output data rate
`timescale 1ns/1ps
`default_nettype none
module fsd_top #(
  parameter int NOTCH_BLOCK_CYCLES = fsd_pkg::NOTCH_BLOCK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic mod_pin,
  input wire fsd_pkg::fsd_axi_req_s axi_req,
  output fsd_pkg::fsd_axi_rsp_s axi_rsp,
  output logic [fsd_pkg::CHAN_W-1:0] chan_sel,
  output logic chop_swap,
  output logic irq
);
  typedef struct packed {
    logic [1:0] sync;
    fsd_pkg::fsd_state_e st;
    fsd_pkg::fsd_cfg_s cfg;
    logic [fsd_pkg::CHAN_W-1:0] chan;
    logic aw_have;
    logic [fsd_pkg::AXI_AW-1:0] aw_addr;
    logic w_have;
    logic [fsd_pkg::AXI_DW-1:0] wdata;
    logic [fsd_pkg::AXI_SW-1:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [fsd_pkg::AXI_DW-1:0] rdata;
    logic [1:0] rresp;
    logic [fsd_pkg::DEC_W-1:0] dec_cnt;
    logic [2:0] scnt;
    logic [4:0] pcnt;
    logic [fsd_pkg::ACC_W-1:0] psum;
    logic [fsd_pkg::RES_W-1:0] prev;
    logic have_prev;
    logic swap;
    logic [fsd_pkg::RES_W-1:0] result;
    logic ready;
    logic [fsd_pkg::IRQ_W-1:0] irq_st;
    logic [fsd_pkg::IRQ_W-1:0] irq_en;
  } fsd_top_s;

  fsd_top_s s_ff;
  fsd_top_s nxt_s;
  logic sinc_restart;
  logic sinc_tick;
  logic notch_restart;
  logic signed [fsd_pkg::IN_W-1:0] sinc_din;
  logic signed [fsd_pkg::IN_W-1:0] notch_sum;
  logic [fsd_pkg::ACC_W-1:0] sinc_dout;
  logic sinc_dvalid;

  ////////////////////////////////////////////////////////////////////////////
  // byte-lane merge
  function automatic logic [fsd_pkg::AXI_DW-1:0] merge(
    input logic [fsd_pkg::AXI_DW-1:0] old_v,
    input logic [fsd_pkg::AXI_DW-1:0] new_v,
    input logic [fsd_pkg::AXI_SW-1:0] strb
  );
    logic [fsd_pkg::AXI_DW-1:0] r;
    r = old_v;
    for (int b = 0; b < fsd_pkg::AXI_SW; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [fsd_pkg::AXI_DW-1:0] cfg_word(input fsd_pkg::fsd_cfg_s c);
    logic [fsd_pkg::AXI_DW-1:0] w;
    w = '0;
    w[fsd_pkg::CTRL_RATE_LSB +: fsd_pkg::RATE_W] = c.rate;
    w[fsd_pkg::CTRL_AVG_LO_BIT] = c.avg[0];
    w[fsd_pkg::CTRL_AVG_HI_BIT] = c.avg[1];
    w[fsd_pkg::CTRL_SINC4_BIT] = c.sinc4;
    w[fsd_pkg::CTRL_CHOP_BIT] = c.chop;
    w[fsd_pkg::CTRL_SIXTY_BIT] = c.sixty;
    w[fsd_pkg::CTRL_RUN_BIT] = c.run;
    return w;
  endfunction : cfg_word

  ////////////////////////////////////////////////////////////////////////////
  // handshake readies
  always_comb begin
    axi_rsp.awready = !s_ff.aw_have && !s_ff.bvalid;
    axi_rsp.wready = !s_ff.w_have && !s_ff.bvalid;
    axi_rsp.bvalid = s_ff.bvalid;
    axi_rsp.bresp = s_ff.bresp;
    axi_rsp.arready = !s_ff.rvalid;
    axi_rsp.rvalid = s_ff.rvalid;
    axi_rsp.rdata = s_ff.rdata;
    axi_rsp.rresp = s_ff.rresp;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [fsd_pkg::AXI_DW-1:0] cw;
    logic cfg_restart;
    logic restart;
    logic rd_clr;
    logic fast;
    logic fast_done;
    logic got;
    logic emit;
    logic [fsd_pkg::IRQ_W-1:0] clr;
    logic [fsd_pkg::IRQ_W-1:0] set;
    logic [fsd_pkg::RATE_W-1:0] rate_eff;
    logic [fsd_pkg::DEC_W-1:0] dmax;
    logic [2:0] skip;
    logic [2:0] sh;
    logic [4:0] avg_last;
    logic [fsd_pkg::ACC_W-1:0] psum_n;
    logic [fsd_pkg::ACC_W-1:0] conv_acc;
    logic [fsd_pkg::RES_W-1:0] conv;
    logic [fsd_pkg::RES_W-1:0] sv;
    logic [fsd_pkg::RES_W:0] pair;
    cw = '0;
    cfg_restart = 1'b0;
    rd_clr = 1'b0;
    fast_done = 1'b0;
    got = 1'b0;
    emit = 1'b0;
    clr = '0;
    set = '0;
    psum_n = '0;
    conv_acc = '0;
    conv = '0;
    sv = '0;
    pair = '0;
    nxt_s = s_ff;
    nxt_s.sync = {s_ff.sync[0], mod_pin};

    // register bus: write channel pair
    if (axi_req.awvalid && axi_rsp.awready) begin
      nxt_s.aw_have = 1'b1;
      nxt_s.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && axi_rsp.wready) begin
      nxt_s.w_have = 1'b1;
      nxt_s.wdata = axi_req.wdata;
      nxt_s.wstrb = axi_req.wstrb;
    end
    if (s_ff.bvalid && axi_req.bready) begin
      nxt_s.bvalid = 1'b0;
    end
    if (s_ff.aw_have && s_ff.w_have) begin
      nxt_s.aw_have = 1'b0;
      nxt_s.w_have = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = fsd_pkg::RESP_OKAY;
      unique case ({s_ff.aw_addr[fsd_pkg::AXI_AW-1:2], 2'h0})
        fsd_pkg::OFS_CTRL: begin
          cw = merge(cfg_word(s_ff.cfg), s_ff.wdata, s_ff.wstrb);
          nxt_s.cfg.rate = cw[fsd_pkg::CTRL_RATE_LSB +: fsd_pkg::RATE_W];
          nxt_s.cfg.avg = {cw[fsd_pkg::CTRL_AVG_HI_BIT], cw[fsd_pkg::CTRL_AVG_LO_BIT]};
          nxt_s.cfg.sinc4 = cw[fsd_pkg::CTRL_SINC4_BIT];
          nxt_s.cfg.chop = cw[fsd_pkg::CTRL_CHOP_BIT];
          nxt_s.cfg.sixty = cw[fsd_pkg::CTRL_SIXTY_BIT];
          nxt_s.cfg.run = cw[fsd_pkg::CTRL_RUN_BIT];
          cfg_restart = 1'b1;
        end
        fsd_pkg::OFS_CHANNEL: begin
          cw = merge({{(fsd_pkg::AXI_DW-fsd_pkg::CHAN_W){1'b0}}, s_ff.chan}, s_ff.wdata, s_ff.wstrb);
          nxt_s.chan = cw[fsd_pkg::CHAN_W-1:0];
          cfg_restart = 1'b1;
        end
        fsd_pkg::OFS_IRQ_CLEAR: begin
          clr = s_ff.wdata[fsd_pkg::IRQ_W-1:0] & {fsd_pkg::IRQ_W{s_ff.wstrb[0]}};
        end
        fsd_pkg::OFS_IRQ_ENABLE: begin
          cw = merge({{(fsd_pkg::AXI_DW-fsd_pkg::IRQ_W){1'b0}}, s_ff.irq_en}, s_ff.wdata, s_ff.wstrb);
          nxt_s.irq_en = cw[fsd_pkg::IRQ_W-1:0];
        end
        fsd_pkg::OFS_STATUS, fsd_pkg::OFS_DATA_LO, fsd_pkg::OFS_DATA_HI, fsd_pkg::OFS_IRQ_STATUS: begin
        end
        default: begin
          nxt_s.bresp = fsd_pkg::RESP_DECERR;
        end
      endcase
    end

    // register bus: read channel
    if (s_ff.rvalid && axi_req.rready) begin
      nxt_s.rvalid = 1'b0;
    end
    if (axi_req.arvalid && axi_rsp.arready) begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rresp = fsd_pkg::RESP_OKAY;
      nxt_s.rdata = '0;
      unique case ({axi_req.araddr[fsd_pkg::AXI_AW-1:2], 2'h0})
        fsd_pkg::OFS_CTRL: nxt_s.rdata = cfg_word(s_ff.cfg);
        fsd_pkg::OFS_CHANNEL: nxt_s.rdata[fsd_pkg::CHAN_W-1:0] = s_ff.chan;
        fsd_pkg::OFS_STATUS: begin
          nxt_s.rdata[fsd_pkg::STAT_READY_BIT] = s_ff.ready;
          nxt_s.rdata[fsd_pkg::STAT_SWAP_BIT] = s_ff.swap;
          nxt_s.rdata[fsd_pkg::STAT_FAST_BIT] = s_ff.cfg.avg != fsd_pkg::AVG_OFF;
        end
        fsd_pkg::OFS_DATA_LO: begin
          nxt_s.rdata = s_ff.result[fsd_pkg::AXI_DW-1:0];
          rd_clr = 1'b1;
        end
        fsd_pkg::OFS_DATA_HI: nxt_s.rdata = s_ff.result[fsd_pkg::RES_W-1:fsd_pkg::AXI_DW];
        fsd_pkg::OFS_IRQ_STATUS: nxt_s.rdata[fsd_pkg::IRQ_W-1:0] = s_ff.irq_st;
        fsd_pkg::OFS_IRQ_ENABLE: nxt_s.rdata[fsd_pkg::IRQ_W-1:0] = s_ff.irq_en;
        fsd_pkg::OFS_IRQ_CLEAR: begin
        end
        default: nxt_s.rresp = fsd_pkg::RESP_DECERR;
      endcase
    end

    // filter sequencing
    nxt_s.st = s_ff.cfg.run ? fsd_pkg::ST_RUN : fsd_pkg::ST_IDLE;
    restart = cfg_restart || (s_ff.st == fsd_pkg::ST_IDLE);
    fast = s_ff.cfg.avg != fsd_pkg::AVG_OFF;
    rate_eff = (s_ff.cfg.rate == '0) ? fsd_pkg::RATE_W'(1) : s_ff.cfg.rate;
    dmax = {rate_eff, {fsd_pkg::DEC_SHIFT{1'b0}}} - 1'b1;
    skip = s_ff.cfg.sinc4 ? fsd_pkg::SINC4_SKIP : fsd_pkg::SINC3_SKIP;
    unique case (s_ff.cfg.avg)
      fsd_pkg::AVG_BY2: sh = fsd_pkg::SH_BY2;
      fsd_pkg::AVG_BY8: sh = fsd_pkg::SH_BY8;
      fsd_pkg::AVG_BY16: sh = fsd_pkg::SH_BY16;
      fsd_pkg::AVG_OFF: sh = '0;
    endcase
    avg_last = 5'((5'h1 << sh) - 5'h1);
    if (restart) begin
      nxt_s.dec_cnt = dmax;
      nxt_s.scnt = '0;
      nxt_s.pcnt = '0;
      nxt_s.psum = '0;
      nxt_s.have_prev = 1'b0;
      nxt_s.swap = 1'b0;
    end else begin
      nxt_s.dec_cnt = (s_ff.dec_cnt == '0) ? dmax : s_ff.dec_cnt - 1'b1;
      if (sinc_dvalid) begin
        if (fast) begin
          if (s_ff.scnt < skip) begin
            // unsettled sinc words discarded
            nxt_s.scnt = s_ff.scnt + 1'b1;
          end else begin
            psum_n = s_ff.psum + sinc_dout;
            if (s_ff.pcnt == avg_last) begin
              conv_acc = $signed(psum_n) >>> sh;
              conv = conv_acc[fsd_pkg::RES_W-1:0];
              got = 1'b1;
              nxt_s.scnt = '0;
              nxt_s.pcnt = '0;
              nxt_s.psum = '0;
            end else begin
              nxt_s.psum = psum_n;
              nxt_s.pcnt = s_ff.pcnt + 1'b1;
            end
          end
        end else begin
          conv = sinc_dout[fsd_pkg::RES_W-1:0];
          got = 1'b1;
        end
      end
      if (got) begin
        if (fast && s_ff.cfg.chop) begin
          sv = s_ff.swap ? -conv : conv;
          nxt_s.swap = !s_ff.swap;
          nxt_s.prev = sv;
          nxt_s.have_prev = 1'b1;
          if (s_ff.have_prev) begin
            pair = {sv[fsd_pkg::RES_W-1], sv} + {s_ff.prev[fsd_pkg::RES_W-1], s_ff.prev};
            nxt_s.result = pair[fsd_pkg::RES_W:1];
            emit = 1'b1;
          end
        end else begin
          nxt_s.result = conv;
          emit = 1'b1;
        end
      end
    end

    // ready flag and sticky interrupt bits, set beats clear
    set[fsd_pkg::IRQ_CONV_BIT] = emit;
    set[fsd_pkg::IRQ_OVR_BIT] = emit && s_ff.ready && !rd_clr;
    nxt_s.ready = emit || (s_ff.ready && !rd_clr);
    nxt_s.irq_st = set | (s_ff.irq_st & ~clr);

    notch_restart = restart;
    sinc_tick = !restart && (s_ff.dec_cnt == '0);
    fast_done = fast && sinc_tick && (s_ff.scnt == skip) && (s_ff.pcnt == avg_last);
    sinc_restart = restart || fast_done;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // filter stages
  always_comb begin
    if (s_ff.cfg.sixty && (s_ff.cfg.rate == fsd_pkg::NOTCH_RATE_WORD) && (s_ff.cfg.avg == fsd_pkg::AVG_BY16)) begin
      sinc_din = notch_sum;
    end else begin
      sinc_din = s_ff.sync[1] ? fsd_pkg::IN_W'(1) : -fsd_pkg::IN_W'(1);
    end
  end

  fsd_notch #(
    .BLOCK_CYCLES(NOTCH_BLOCK_CYCLES)
  ) u_notch (
    .mclk(mclk),
    .rst(rst),
    .restart(notch_restart),
    .din_bit(s_ff.sync[1]),
    .sum(notch_sum)
  );

  fsd_sinc u_sinc (
    .mclk(mclk),
    .rst(rst),
    .restart(sinc_restart),
    .order4(s_ff.cfg.sinc4),
    .tick(sinc_tick),
    .din(sinc_din),
    .dout(sinc_dout),
    .dvalid(sinc_dvalid)
  );

  assign chan_sel = s_ff.chan;
  assign chop_swap = s_ff.swap;
  assign irq = |(s_ff.irq_st & s_ff.irq_en);
endmodule : fsd_top
`default_nettype wire

/* verilog/fsd_pkg.sv */
package fsd_pkg;
  localparam int AXI_AW = 8;
  localparam int AXI_DW = 32;
  localparam int AXI_SW = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // register byte offsets
  localparam logic [AXI_AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_CHANNEL = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_STATUS = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_DATA_LO = 8'h0C;
  localparam logic [AXI_AW-1:0] OFS_DATA_HI = 8'h10;
  localparam logic [AXI_AW-1:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [AXI_AW-1:0] OFS_IRQ_CLEAR = 8'h18;
  localparam logic [AXI_AW-1:0] OFS_IRQ_ENABLE = 8'h1C;

  // control field layout
  localparam int RATE_W = 10;
  localparam int CTRL_RATE_LSB = 0;
  localparam int CTRL_AVG_LO_BIT = 10;
  localparam int CTRL_AVG_HI_BIT = 11;
  localparam int CTRL_SINC4_BIT = 12;
  localparam int CTRL_CHOP_BIT = 13;
  localparam int CTRL_SIXTY_BIT = 14;
  localparam int CTRL_RUN_BIT = 15;
  localparam int CHAN_W = 4;
  localparam int IRQ_W = 2;
  localparam int IRQ_CONV_BIT = 0;
  localparam int IRQ_OVR_BIT = 1;
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_SWAP_BIT = 1;
  localparam int STAT_FAST_BIT = 2;

  // averaging select codes and shifts
  localparam logic [1:0] AVG_OFF = 2'h0;
  localparam logic [1:0] AVG_BY2 = 2'h1;
  localparam logic [1:0] AVG_BY8 = 2'h2;
  localparam logic [1:0] AVG_BY16 = 2'h3;
  localparam logic [2:0] SH_BY2 = 3'h1;
  localparam logic [2:0] SH_BY8 = 3'h3;
  localparam logic [2:0] SH_BY16 = 3'h4;

  // filter structure
  localparam int DEC_SHIFT = 10;
  localparam int DEC_W = RATE_W + DEC_SHIFT;
  localparam int SINC_STAGES = 4;
  localparam logic [2:0] SINC3_SKIP = 3'h2;
  localparam logic [2:0] SINC4_SKIP = 3'h3;
  localparam int IN_W = 20;
  localparam int ACC_W = 104;
  localparam int RES_W = 64;
  localparam logic [RATE_W-1:0] NOTCH_RATE_WORD = 10'h060;
  localparam int NOTCH_TAPS = 16;
  localparam int NOTCH_PTR_W = 4;
  localparam int NOTCH_CNT_W = 24;
  localparam int CLK_HZ = 10_000_000;
  localparam int NOTCH_HZ = 60;
  localparam int NOTCH_BLOCK_CYCLES = CLK_HZ / (NOTCH_HZ * NOTCH_TAPS);

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } fsd_state_e;

  typedef struct packed {
    logic [RATE_W-1:0] rate;
    logic [1:0] avg;
    logic sinc4;
    logic chop;
    logic sixty;
    logic run;
  } fsd_cfg_s;

  typedef struct packed {
    logic [AXI_AW-1:0] awaddr;
    logic awvalid;
    logic [AXI_DW-1:0] wdata;
    logic [AXI_SW-1:0] wstrb;
    logic wvalid;
    logic bready;
    logic [AXI_AW-1:0] araddr;
    logic arvalid;
    logic rready;
  } fsd_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [AXI_DW-1:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } fsd_axi_rsp_s;
endpackage : fsd_pkg

/* verilog/fsd_sinc.sv */
`timescale 1ns/1ps
`default_nettype none
module fsd_sinc (
  input wire logic mclk,
  input wire logic rst,
  input wire logic restart,
  input wire logic order4,
  input wire logic tick,
  input wire logic signed [fsd_pkg::IN_W-1:0] din,
  output logic [fsd_pkg::ACC_W-1:0] dout,
  output logic dvalid
);
  typedef struct packed {
    logic [fsd_pkg::SINC_STAGES-1:0][fsd_pkg::ACC_W-1:0] integ;
    logic [fsd_pkg::SINC_STAGES-1:0][fsd_pkg::ACC_W-1:0] dly;
    logic [fsd_pkg::ACC_W-1:0] dout;
    logic dvalid;
  } fsd_sinc_s;

  fsd_sinc_s s_ff;
  fsd_sinc_s nxt_s;

  always_comb begin
    logic [fsd_pkg::ACC_W-1:0] inx;
    logic [fsd_pkg::ACC_W-1:0] cur;
    logic [fsd_pkg::ACC_W-1:0] diff;
    int ord;
    inx = {{(fsd_pkg::ACC_W-fsd_pkg::IN_W){din[fsd_pkg::IN_W-1]}}, din};
    cur = '0;
    diff = '0;
    ord = order4 ? 4 : 3;
    nxt_s = s_ff;
    nxt_s.dvalid = 1'b0;
    nxt_s.integ[0] = s_ff.integ[0] + inx;
    for (int k = 1; k < fsd_pkg::SINC_STAGES; k++) begin
      nxt_s.integ[k] = s_ff.integ[k] + s_ff.integ[k-1];
    end
    if (tick) begin
      cur = order4 ? s_ff.integ[3] : s_ff.integ[2];
      for (int k = 0; k < fsd_pkg::SINC_STAGES; k++) begin
        if (k < ord) begin
          diff = cur - s_ff.dly[k];
          nxt_s.dly[k] = cur;
          cur = diff;
        end
      end
      nxt_s.dout = cur;
      nxt_s.dvalid = 1'b1;
    end
    if (restart) begin
      // new window starts with the current sample, so no sample is lost
      nxt_s.integ = '0;
      nxt_s.dly = '0;
      nxt_s.integ[0] = inx;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign dout = s_ff.dout;
  assign dvalid = s_ff.dvalid;
endmodule : fsd_sinc
`default_nettype wire

/* verilog/fsd_notch.sv */
`timescale 1ns/1ps
`default_nettype none
module fsd_notch #(
  parameter int BLOCK_CYCLES = fsd_pkg::NOTCH_BLOCK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic restart,
  input wire logic din_bit,
  output logic signed [fsd_pkg::IN_W-1:0] sum
);
  typedef struct packed {
    logic [fsd_pkg::NOTCH_CNT_W-1:0] cnt;
    logic [fsd_pkg::IN_W-1:0] bsum;
    logic [fsd_pkg::NOTCH_TAPS-1:0][fsd_pkg::IN_W-1:0] taps;
    logic [fsd_pkg::IN_W-1:0] msum;
    logic [fsd_pkg::NOTCH_PTR_W-1:0] wptr;
  } fsd_notch_s;

  localparam logic [fsd_pkg::NOTCH_CNT_W-1:0] CNT_LAST = fsd_pkg::NOTCH_CNT_W'(BLOCK_CYCLES - 1);
  localparam logic [fsd_pkg::IN_W-1:0] STEP_UP = fsd_pkg::IN_W'(1);

  fsd_notch_s s_ff;
  fsd_notch_s nxt_s;

  always_comb begin
    logic [fsd_pkg::IN_W-1:0] bfin;
    bfin = din_bit ? s_ff.bsum + STEP_UP : s_ff.bsum - STEP_UP;
    nxt_s = s_ff;
    if (restart) begin
      nxt_s = '0;
    end else if (s_ff.cnt == CNT_LAST) begin
      // boxcar spanning one sixtieth of a second
      nxt_s.msum = s_ff.msum + bfin - s_ff.taps[s_ff.wptr];
      nxt_s.taps[s_ff.wptr] = bfin;
      nxt_s.wptr = s_ff.wptr + 1'b1;
      nxt_s.bsum = '0;
      nxt_s.cnt = '0;
    end else begin
      nxt_s.bsum = bfin;
      nxt_s.cnt = s_ff.cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign sum = s_ff.msum;
endmodule : fsd_notch
`default_nettype wire

/* verif/fsd_top_props.sv */
`timescale 1ns/1ps
`default_nettype none
module fsd_top_props #(
  parameter int NOTCH_BLOCK_CYCLES = fsd_pkg::NOTCH_BLOCK_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic mod_pin,
  input wire fsd_pkg::fsd_axi_req_s axi_req,
  input wire fsd_pkg::fsd_axi_rsp_s axi_rsp,
  input wire logic [fsd_pkg::CHAN_W-1:0] chan_sel,
  input wire logic chop_swap,
  input wire logic irq
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // bus response timing and holding
  chk_bvalid_hold: assert property (axi_rsp.bvalid && !axi_req.bready |=> axi_rsp.bvalid && $stable(axi_rsp.bresp))
    else $error("write response dropped before acceptance");
  chk_rvalid_hold: assert property (axi_rsp.rvalid && !axi_req.rready |=>
    axi_rsp.rvalid && $stable(axi_rsp.rdata) && $stable(axi_rsp.rresp))
    else $error("read response changed before acceptance");
  chk_read_latency: assert property (axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
    else $error("read data not one cycle after address");
  chk_write_latency: assert property (axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
    |=> !axi_rsp.bvalid ##1 axi_rsp.bvalid)
    else $error("write response not two cycles after transfer");
  chk_ar_blocked: assert property (axi_rsp.rvalid |-> !axi_rsp.arready)
    else $error("read address accepted while response pending");
  chk_aw_blocked: assert property (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
    else $error("write accepted while response pending");
  chk_bresp_code: assert property (axi_rsp.bvalid |->
    axi_rsp.bresp == fsd_pkg::RESP_OKAY || axi_rsp.bresp == fsd_pkg::RESP_DECERR)
    else $error("bad write response code");
  chk_decerr_zero: assert property (axi_rsp.rvalid && axi_rsp.rresp == fsd_pkg::RESP_DECERR |-> axi_rsp.rdata == 32'h0)
    else $error("error read returned nonzero data");

  ////////////////////////////////////////////////////////////////////////////
  // side effects of register writes
  chk_irq_fall: assert property ($fell(irq) |-> $rose(axi_rsp.bvalid))
    else $error("interrupt fell without a register write");
  chk_chan_write: assert property ($changed(chan_sel) |-> $rose(axi_rsp.bvalid))
    else $error("channel changed without a register write");
endmodule : fsd_top_props
`default_nettype wire

/* verif/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int NBC = 8;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic mod_pin = 1'h1;
  fsd_pkg::fsd_axi_req_s axi_req = '0;
  fsd_pkg::fsd_axi_rsp_s axi_rsp;
  logic [fsd_pkg::CHAN_W-1:0] chan_sel;
  logic chop_swap;
  logic irq;
  int mismatches = 0;
  int num_checks = 0;
  int cyc = 0;
  int t_irq = 0;
  int p = 0;
  int b = 0;
  int avgs [4] = '{0, 2, 8, 16};
  logic [7:0] regs [7];
  logic [31:0] rd_g;
  logic [1:0] resp_g;
  logic [63:0] res;
  logic [31:0] st;
  logic swap_s;

  always #50 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;

  fsd_top #(.NOTCH_BLOCK_CYCLES(NBC)) u_fsd_top (
    .mclk(mclk), .rst(rst), .mod_pin(mod_pin), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .chan_sel(chan_sel), .chop_swap(chop_swap), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // checking and closing
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic conclude();
    $display("mismatches %0d checks %0d", mismatches, num_checks);
    if (mismatches == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////////
  // bus master tasks
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic aw_done;
    logic w_done;
    aw_done = 1'h0;
    w_done = 1'h0;
    @(posedge mclk);
    axi_req.awaddr <= a;
    axi_req.awvalid <= 1'h1;
    axi_req.wdata <= d;
    axi_req.wstrb <= 4'hF;
    axi_req.wvalid <= 1'h1;
    while (!(aw_done && w_done)) begin
      @(negedge mclk);
      aw_done = aw_done || (axi_req.awvalid && axi_rsp.awready);
      w_done = w_done || (axi_req.wvalid && axi_rsp.wready);
      @(posedge mclk);
      if (aw_done) axi_req.awvalid <= 1'h0;
      if (w_done) axi_req.wvalid <= 1'h0;
    end
    do @(negedge mclk); while (axi_rsp.bvalid !== 1'h1);
    @(posedge mclk);
    axi_req.bready <= 1'h1;
    @(negedge mclk);
    resp_g = axi_rsp.bresp;
    @(posedge mclk);
    axi_req.bready <= 1'h0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a);
    logic hit;
    hit = 1'h0;
    @(posedge mclk);
    axi_req.araddr <= a;
    axi_req.arvalid <= 1'h1;
    while (!hit) begin
      @(negedge mclk);
      hit = axi_rsp.arready;
      @(posedge mclk);
    end
    axi_req.arvalid <= 1'h0;
    do @(negedge mclk); while (axi_rsp.rvalid !== 1'h1);
    @(posedge mclk);
    axi_req.rready <= 1'h1;
    @(negedge mclk);
    rd_g = axi_rsp.rdata;
    resp_g = axi_rsp.rresp;
    @(posedge mclk);
    axi_req.rready <= 1'h0;
  endtask : axi_read

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    axi_read(a);
    check({32'h0, rd_g}, {32'h0, e});
  endtask : rchk

  // waits for a conversion, checks its spacing, fetches and clears
  task automatic conv(input int base, input int lo, input int hi, input logic rd);
    int d;
    do @(negedge mclk); while (irq !== 1'h1);
    d = cyc - base;
    t_irq = cyc;
    check(64'(d >= lo && d <= hi), 64'h1);
    if (rd) begin
      axi_read(fsd_pkg::OFS_DATA_HI);
      res[63:32] = rd_g;
      axi_read(fsd_pkg::OFS_DATA_LO);
      res[31:0] = rd_g;
    end
    axi_read(fsd_pkg::OFS_IRQ_STATUS);
    st = rd_g;
    axi_write(fsd_pkg::OFS_IRQ_CLEAR, 32'h3);
  endtask : conv

  ////////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    repeat (95000) @(posedge mclk);
    mismatches++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////
  // tests
  initial begin
    regs = '{fsd_pkg::OFS_CTRL, fsd_pkg::OFS_CHANNEL, fsd_pkg::OFS_STATUS, fsd_pkg::OFS_DATA_LO,
      fsd_pkg::OFS_DATA_HI, fsd_pkg::OFS_IRQ_STATUS, fsd_pkg::OFS_IRQ_ENABLE};
    repeat (12) @(posedge mclk);
    rst <= 1'h0;
    for (int i = 0; i < 7; i++) begin
      rchk(regs[i], 32'h0);
    end
    axi_read(8'h20);
    check(64'(resp_g), 64'(fsd_pkg::RESP_DECERR));
    axi_write(8'h20, 32'h1);
    check(64'(resp_g), 64'(fsd_pkg::RESP_DECERR));
    axi_write(fsd_pkg::OFS_STATUS, 32'hFFFF_FFFF);
    check(64'(resp_g), 64'(fsd_pkg::RESP_OKAY));
    rchk(fsd_pkg::OFS_STATUS, 32'h0);
    axi_write(fsd_pkg::OFS_CTRL, 32'h7FFF);
    rchk(fsd_pkg::OFS_CTRL, 32'h7FFF);
    rchk(fsd_pkg::OFS_STATUS, 32'h4);
    axi_write(fsd_pkg::OFS_CTRL, 32'h73FF);
    rchk(fsd_pkg::OFS_STATUS, 32'h0);
    axi_write(fsd_pkg::OFS_IRQ_ENABLE, 32'h1);
    rchk(fsd_pkg::OFS_IRQ_ENABLE, 32'h1);
    // third order with each nonzero averaging code
    for (int c = 1; c < 4; c++) begin
      p = (2 + avgs[c]) * 1024;
      axi_write(fsd_pkg::OFS_CTRL, 32'h8001 | (32'(c) << 10));
      conv(cyc, p - 4, p + 8, 1'h1);
      check(res, 64'h4000_0000);
    end
    // channel change in mid conversion
    p = 4096;
    axi_write(fsd_pkg::OFS_CTRL, 32'h8401);
    repeat (1000) @(posedge mclk);
    axi_write(fsd_pkg::OFS_CHANNEL, 32'h5);
    b = cyc;
    check(64'(chan_sel), 64'h5);
    conv(b, p - 4, p + 8, 1'h1);
    check(res, 64'h4000_0000);
    // fourth order, input step between conversions
    p = 5120;
    axi_write(fsd_pkg::OFS_CTRL, 32'h9401);
    conv(cyc, p - 4, p + 8, 1'h1);
    check(res, 64'h0000_0100_0000_0000);
    check(64'(st), 64'h1);
    rchk(fsd_pkg::OFS_STATUS, 32'h4);
    repeat (2000) @(posedge mclk);
    mod_pin <= 1'h0;
    conv(t_irq, p, p, 1'h1);
    conv(t_irq, p, p, 1'h1);
    check(res, 64'hFFFF_FF00_0000_0000);
    // chopped operation
    p = 4096;
    axi_write(fsd_pkg::OFS_CTRL, 32'hA401);
    conv(cyc, 2 * p - 4, 2 * p + 8, 1'h1);
    swap_s = chop_swap;
    conv(t_irq, p, p, 1'h1);
    check(64'(chop_swap), 64'(!swap_s));
    check(res, 64'h0);
    // averaging off, then an unread result overruns
    axi_write(fsd_pkg::OFS_CTRL, 32'h8001);
    conv(cyc, 0, 4096, 1'h1);
    conv(t_irq, 1024, 1024, 1'h0);
    conv(t_irq, 1024, 1024, 1'h1);
    check(64'(st), 64'h3);
    check(64'(irq), 64'h0);
    rchk(fsd_pkg::OFS_STATUS, 32'h0);
    axi_write(fsd_pkg::OFS_CTRL, 32'h0);
    conclude();
  end
endmodule : tb_top

bind fsd_top fsd_top_props #(.NOTCH_BLOCK_CYCLES(NOTCH_BLOCK_CYCLES)) u_fsd_top_props (
  .mclk(mclk), .rst(rst), .mod_pin(mod_pin), .axi_req(axi_req), .axi_rsp(axi_rsp),
  .chan_sel(chan_sel), .chop_swap(chop_swap), .irq(irq)
);
`default_nettype wire
